// ===== rtl/mrc_frame_if.sv
/*
  Carrier between the serial frame engine and the register core.
  Assumes both ends run on the one system clock.
*/
`default_nettype none

interface mrc_frame_if;
  logic       done;     // one-cycle pulse, good 32-bit frame ended
  logic       len_err;  // one-cycle pulse, frame with wrong bit count
  logic [31:0] rx_word; // received frame, stable after done
  logic [31:0] tx_word; // answer shifted out in the next frame

  modport link (output done, output len_err, output rx_word,
                input tx_word);
  modport core (input done, input len_err, input rx_word,
                output tx_word);
endinterface : mrc_frame_if

`default_nettype wire

// ===== rtl/mrc_pkg.sv
/*
  Constants and types shared by the mode and regulator control bank.
  Assumes a 32-bit serial frame: bit 31 is write, 30:25 the address,
  23:8 register data, 7:0 a check byte that this bank does not verify.
*/
`default_nettype none

package mrc_pkg;

  // ------------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------------
  localparam int          FRM_BITS  = 32;
  localparam int          RW_POS    = 31;
  localparam int          ADDR_MSB  = 30;
  localparam int          ADDR_LSB  = 25;
  localparam int          DATA_MSB  = 23;
  localparam int          DATA_LSB  = 8;
  localparam logic [5:0]  CNT_FULL  = 6'h20;  // bits in a good frame
  localparam logic [5:0]  CNT_MAX   = 6'h21;  // counter saturates here
  localparam logic [5:0]  CNT_ZERO  = 6'h00;
  localparam logic [5:0]  CNT_ONE   = 6'h01;

  // ------------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------------
  localparam logic [5:0]  ADDR_MODE = 6'h04;
  localparam logic [5:0]  ADDR_REGC = 6'h05;
  localparam logic [5:0]  ADDR_COMM = 6'h06;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int POS_PLL_LOCK = 16;
  localparam int POS_EXT_SEL  = 15;
  localparam int POS_EXT_DIS  = 14;
  localparam int POS_NORMAL   = 13;
  localparam int POS_WAKE_INPUT_2    = 10;
  localparam int POS_WAKE_INPUT_1    = 9;
  localparam int POS_STBY     = 8;
  localparam int POS_PD_OVR   = 23;
  localparam int DIS_MSB      = 22;
  localparam int DIS_LSB      = 16;
  localparam int EN_MSB       = 14;
  localparam int EN_LSB       = 8;
  localparam int POS_CLK_ERR  = 12;
  localparam int POS_REQ_ERR  = 11;
  localparam int NRAIL        = 7;
  localparam int NMODE_REQ    = 2;

  // ------------------------------------------------------------------
  // writable masks and reset values
  // ------------------------------------------------------------------
  localparam logic [23:0] WMASK_MODE = 24'h004700;
  localparam logic [23:0] WMASK_REGC = 24'hFF7F00;
  localparam logic [23:0] WMASK_COMM = 24'h001800;
  localparam logic [23:0] DATA_MASK  = 24'hFFFF00;
  localparam logic        NORMAL_RST = 1'b1;

  typedef logic [23:0] mrc_word_t;
  typedef logic [31:0] mrc_frame_t;

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_FRAME = 1'b1
  } mrc_spi_st_t;

endpackage : mrc_pkg

`default_nettype wire

// ===== rtl/mrc_regs.sv
/*
  Mode and regulator control register bank behind the main-domain
  serial port, with a sticky access-error register.
  Assumes status inputs and regulator-side logic run on clk_sys_i and
  that request pulses are consumed in the cycle they appear.
*/
// How it works
// - pll lock shown live at bit 16
// - bit 15 shows external clock selected
// - write one at bit 14 blocks external clock
// - bit 13 shows normal mode, resets one
// - bits 10, 9 disable wake inputs
// - write one at bit 8 requests standby
// - bit 23 stored, forces pulldown off
// - override clear lets logic drive pulldown
// - bit 22 one requests preregulator off
// - bit 21 one requests boost off
// - bits 20..18 request step-down converters off
// - bits 17, 16 request linear regulators off
// - bit 14 one re-enables preregulator after disable
// - bit 13 one requests boost on
// - bits 12..10 request step-down converters on
// - bits 9, 8 request linear regulators on
// - zero request bits change nothing
// - bad access sets sticky bit, write clears
`default_nettype none

module mrc_regs (
  input  wire logic                   clk_sys_i,
  input  wire logic                   srst_i,
  input  wire logic                   csb_n_i,
  input  wire logic                   sclk_i,
  input  wire logic                   mosi_i,
  output logic                        miso_o,
  input  wire logic                   pll_lock_i,
  input  wire logic                   ext_clk_selected_i,
  input  wire logic                   main_normal_i,
  input  wire logic                   pulldown_auto_i,
  output logic                        external_clock_select_disable_o,
  output logic                        standby_request_o,
  output logic                        wake_input_1_disable_o,
  output logic                        wake_input_2_disable_o,
  output logic                        preregulator_pulldown_en_o,
  output logic [mrc_pkg::NRAIL-1:0]   rail_disable_req_o,
  output logic [mrc_pkg::NRAIL-1:0]   rail_enable_req_o
);
  import mrc_pkg::*;

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  mrc_frame_if frm ();

  logic                 pll_lock_live_q;
  logic                 ext_sel_live_q;
  logic                 normal_q;
  logic                 pd_ovr_q;
  logic                 req_err_q;
  logic                 clk_err_q;
  mrc_frame_t           tx_q;
  mrc_frame_t           tx_d;
  mrc_word_t            rd_word;
  mrc_word_t            dat;
  logic [5:0]           addr;
  logic                 is_wr;
  logic                 bad_rsv;
  logic                 access_bad;
  logic                 wr_ok;
  logic                 wr_mode;
  logic                 wr_regc;
  logic                 wr_comm;
  logic [NMODE_REQ-1:0] mode_pulse;

  // ------------------------------------------------------------------
  // address decode helpers
  // ------------------------------------------------------------------

  // true for an address that holds a register
  function automatic logic addr_mapped(input logic [5:0] a);
    return (a == ADDR_MODE) || (a == ADDR_REGC) || (a == ADDR_COMM);
  endfunction : addr_mapped

  // bits that software may legally write as one at an address
  function automatic mrc_word_t wmask_of(input logic [5:0] a);
    mrc_word_t m;
    m = '0;
    case (a)
      ADDR_MODE: m = WMASK_MODE;
      ADDR_REGC: m = WMASK_REGC;
      ADDR_COMM: m = WMASK_COMM;
      default:   m = '0;
    endcase
    return m;
  endfunction : wmask_of

  // ------------------------------------------------------------------
  // serial frame engine
  // ------------------------------------------------------------------
  mrc_spi_frame u_frame (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .csb_n_i   (csb_n_i),
    .sclk_i    (sclk_i),
    .mosi_i    (mosi_i),
    .miso_o    (miso_o),
    .frm       (frm.link)
  );

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------

  // split the received frame
  assign is_wr = frm.rx_word[RW_POS];
  assign addr  = frm.rx_word[ADDR_MSB:ADDR_LSB];
  assign dat   = frm.rx_word[DATA_MSB:0] & DATA_MASK;

  // a write with a one on a reserved or read-only bit is refused
  assign bad_rsv    = is_wr && ((dat & ~wmask_of(addr)) != '0);
  assign access_bad = frm.done && (!addr_mapped(addr) || bad_rsv);
  assign wr_ok      = frm.done && is_wr && addr_mapped(addr) && !bad_rsv;
  assign wr_mode    = wr_ok && (addr == ADDR_MODE);
  assign wr_regc    = wr_ok && (addr == ADDR_REGC);
  assign wr_comm    = wr_ok && (addr == ADDR_COMM);

  // ------------------------------------------------------------------
  // live status capture
  // ------------------------------------------------------------------

  // status inputs sampled every cycle; normal mode resets to one
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pll_lock_live_q <= 1'b0;
      ext_sel_live_q  <= 1'b0;
      normal_q        <= NORMAL_RST;
    end else begin
      pll_lock_live_q <= pll_lock_i;
      ext_sel_live_q  <= ext_clk_selected_i;
      normal_q        <= main_normal_i;
    end
  end

  // ------------------------------------------------------------------
  // stored control fields
  // ------------------------------------------------------------------

  // wake input disables, level fields
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wake_input_1_disable_o <= 1'b0;
      wake_input_2_disable_o <= 1'b0;
    end else if (wr_mode) begin
      wake_input_1_disable_o <= dat[POS_WAKE_INPUT_1];
      wake_input_2_disable_o <= dat[POS_WAKE_INPUT_2];
    end
  end

  // pulldown override, stored and readable
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pd_ovr_q <= 1'b0;
    end else if (wr_regc) begin
      pd_ovr_q <= dat[POS_PD_OVR];
    end
  end

  // pulldown follows the automatic logic unless overridden
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      preregulator_pulldown_en_o <= 1'b0;
    end else begin
      preregulator_pulldown_en_o <= pulldown_auto_i & ~pd_ovr_q;
    end
  end

  // ------------------------------------------------------------------
  // one-shot requests
  // ------------------------------------------------------------------

  // external clock disable and standby, one cycle each
  mrc_req_pulse #(.W(NMODE_REQ)) u_mode_req (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .strobe_i  (wr_mode),
    .bits_i    ({dat[POS_EXT_DIS], dat[POS_STBY]}),
    .pulse_o   (mode_pulse)
  );

  assign external_clock_select_disable_o = mode_pulse[1];
  assign standby_request_o               = mode_pulse[0];

  // regulator disable requests: preregulator, boost, 3 bucks, 2 ldos
  mrc_req_pulse #(.W(NRAIL)) u_dis_req (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .strobe_i  (wr_regc),
    .bits_i    (dat[DIS_MSB:DIS_LSB]),
    .pulse_o   (rail_disable_req_o)
  );

  // regulator enable requests, same rail order
  mrc_req_pulse #(.W(NRAIL)) u_en_req (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .strobe_i  (wr_regc),
    .bits_i    (dat[EN_MSB:EN_LSB]),
    .pulse_o   (rail_enable_req_o)
  );

  // ------------------------------------------------------------------
  // sticky access errors
  // ------------------------------------------------------------------

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      req_err_q <= 1'b0;
    end else if (access_bad) begin
      req_err_q <= 1'b1;
    end else if (wr_comm && dat[POS_REQ_ERR]) begin
      req_err_q <= 1'b0;
    end
  end

  // wrong serial clock count
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      clk_err_q <= 1'b0;
    end else if (frm.len_err) begin
      clk_err_q <= 1'b1;
    end else if (wr_comm && dat[POS_CLK_ERR]) begin
      clk_err_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------

  // readable view of the addressed register, others read zero
  always_comb begin
    rd_word = '0;
    case (addr)
      ADDR_MODE: begin
        rd_word[POS_PLL_LOCK] = pll_lock_live_q;
        rd_word[POS_EXT_SEL]  = ext_sel_live_q;
        rd_word[POS_NORMAL]   = normal_q;
        rd_word[POS_WAKE_INPUT_2]    = wake_input_2_disable_o;
        rd_word[POS_WAKE_INPUT_1]    = wake_input_1_disable_o;
      end
      ADDR_REGC: begin
        rd_word[POS_PD_OVR]   = pd_ovr_q;
      end
      ADDR_COMM: begin
        rd_word[POS_CLK_ERR]  = clk_err_q;
        rd_word[POS_REQ_ERR]  = req_err_q;
      end
      default: rd_word = '0;
    endcase
  end

  // answer frame: echoed address and register data
  always_comb begin
    tx_d = '0;
    tx_d[ADDR_MSB:ADDR_LSB] = addr;
    tx_d[DATA_MSB:DATA_LSB] = rd_word[DATA_MSB:DATA_LSB];
  end

  // answer is latched at frame end and sent in the next frame
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tx_q <= '0;
    end else if (frm.done) begin
      tx_q <= tx_d;
    end
  end

  assign frm.tx_word = tx_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  a_pll_lock_read: assert property (
    frm.done && addr == ADDR_MODE |=>
    tx_q[POS_PLL_LOCK] == $past(pll_lock_i, 2))
    else $error("pll lock not reported");

  a_ext_sel_read: assert property (
    frm.done && addr == ADDR_MODE |=>
    tx_q[POS_EXT_SEL] == $past(ext_clk_selected_i, 2))
    else $error("external clock selection not reported");

  a_ext_dis_pulse: assert property (
    wr_mode && dat[POS_EXT_DIS] |=> external_clock_select_disable_o ##1
    !external_clock_select_disable_o)
    else $error("external clock disable not a single pulse");

  a_normal_reset: assert property (
    disable iff (1'b0) srst_i |=> normal_q)
    else $error("normal status not one after reset");

  a_wake_store: assert property (
    wr_mode |=> wake_input_1_disable_o == $past(dat[POS_WAKE_INPUT_1]) &&
    wake_input_2_disable_o == $past(dat[POS_WAKE_INPUT_2]))
    else $error("wake disables not stored");

  a_standby_pulse: assert property (
    standby_request_o |-> $past(wr_mode) && $past(dat[POS_STBY]))
    else $error("standby request without a write");

  a_pd_override: assert property (
    pd_ovr_q |=> !preregulator_pulldown_en_o)
    else $error("pulldown active while overridden");

  a_pd_auto: assert property (
    !pd_ovr_q && pulldown_auto_i |=> preregulator_pulldown_en_o)
    else $error("pulldown not following automatic control");

  a_dis_requests: assert property (
    wr_regc |=> rail_disable_req_o == $past(dat[DIS_MSB:DIS_LSB]))
    else $error("disable requests do not match write");

  a_en_requests: assert property (
    wr_regc |=> rail_enable_req_o == $past(dat[EN_MSB:EN_LSB]))
    else $error("enable requests do not match write");

  a_no_req_idle: assert property (
    !wr_regc |=> rail_disable_req_o == '0 && rail_enable_req_o == '0)
    else $error("request pulse without a write");

  a_err_sticky: assert property (
    access_bad |=> req_err_q [*2])
    else $error("access error not sticky");

  a_rsv_read: assert property (
    frm.done && addr == ADDR_REGC |=> tx_q[DIS_MSB:EN_LSB] == '0)
    else $error("write-only bits read back");

  a_reset_vals: assert property (
    disable iff (1'b0) srst_i |=> !pd_ovr_q && !req_err_q &&
    !wake_input_1_disable_o && !wake_input_2_disable_o)
    else $error("fields not cleared by reset");

  a_req_single: assert property (
    rail_disable_req_o != '0 |=> rail_disable_req_o == '0 || $past(wr_regc))
    else $error("disable request held");

endmodule : mrc_regs

`default_nettype wire

// ===== rtl/mrc_req_pulse.sv
/*
  One-shot request stage: bits written as one leave as a single-cycle
  pulse, bits written as zero leave nothing.
  Assumes strobe_i is itself a single-cycle pulse.
*/
`default_nettype none

module mrc_req_pulse #(
  parameter int W = 7
) (
  input  wire logic         clk_sys_i,
  input  wire logic         srst_i,
  input  wire logic         strobe_i,
  input  wire logic [W-1:0] bits_i,
  output logic      [W-1:0] pulse_o
);

  // pulse for one cycle, never held
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !strobe_i) begin
      pulse_o <= '0;
    end else begin
      pulse_o <= bits_i;
    end
  end

endmodule : mrc_req_pulse

`default_nettype wire

// ===== rtl/mrc_spi_frame.sv
/*
  Serial frame engine: samples select, clock and data pins, counts bits,
  shifts in the command and shifts out the previous answer.
  Assumes the pins are synchronous to clk_sys_i and each serial clock
  level lasts at least one system clock.
*/
`default_nettype none

module mrc_spi_frame (
  input  wire logic  clk_sys_i,
  input  wire logic  srst_i,
  input  wire logic  csb_n_i,
  input  wire logic  sclk_i,
  input  wire logic  mosi_i,
  output logic       miso_o,
  mrc_frame_if.link  frm
);
  import mrc_pkg::*;

  logic        sclk_q;
  logic        csb_n_q;
  mrc_spi_st_t st_q;
  logic [5:0]  cnt_q;
  mrc_frame_t  rx_q;
  mrc_frame_t  tx_q;
  logic        done_q;
  logic        len_err_q;
  logic        start;
  logic        stop;
  logic        rise;
  logic        fall;

  // ------------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------------
  assign start = csb_n_q & ~csb_n_i;
  assign stop  = ~csb_n_q & csb_n_i;
  assign rise  = sclk_i & ~sclk_q & (st_q == ST_FRAME);
  assign fall  = ~sclk_i & sclk_q & (st_q == ST_FRAME);

  // previous pin levels
  always_ff @(posedge clk_sys_i) begin
    sclk_q <= srst_i ? 1'b0 : sclk_i;
    csb_n_q <= srst_i ? 1'b1 : csb_n_i;
  end

  // frame state
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE:  if (start) st_q <= ST_FRAME;
        ST_FRAME: if (stop) st_q <= ST_IDLE;
      endcase
    end
  end

  // bit counter, saturating so long frames stay wrong
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || start) begin
      cnt_q <= CNT_ZERO;
    end else if (rise && cnt_q != CNT_MAX) begin
      cnt_q <= cnt_q + CNT_ONE;
    end
  end

  // receive shifter, msb first on rising serial clock
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rx_q <= '0;
    end else if (rise) begin
      rx_q <= {rx_q[FRM_BITS-2:0], mosi_i};
    end
  end

  // transmit shifter, next bit on falling serial clock
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tx_q   <= '0;
      miso_o <= 1'b0;
    end else if (start) begin
      tx_q   <= frm.tx_word;
      miso_o <= frm.tx_word[FRM_BITS-1];
    end else if (fall) begin
      tx_q   <= {tx_q[FRM_BITS-2:0], 1'b0};
      miso_o <= tx_q[FRM_BITS-2];
    end
  end

  // end-of-frame pulses
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      done_q    <= 1'b0;
      len_err_q <= 1'b0;
    end else begin
      done_q    <= (st_q == ST_FRAME) & stop & (cnt_q == CNT_FULL);
      len_err_q <= (st_q == ST_FRAME) & stop & (cnt_q != CNT_FULL);
    end
  end

  assign frm.done    = done_q;
  assign frm.len_err = len_err_q;
  assign frm.rx_word = rx_q;

endmodule : mrc_spi_frame

`default_nettype wire

// ===== sim/mrc_host_model.sv
/*
  Host model: serial master that sends one frame and returns the
  answer shifted back during it.
  Assumes mode 0 framing and a system clock shared with the bank.
*/
`default_nettype none

module mrc_host_model (
  input  wire logic clk_sys_i,
  output logic      csb_n_o,
  output logic      sclk_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // idle levels: deselected, serial clock standing low
  // ----------------------------------------------------------------
  initial begin
    csb_n_o = 1'b1;
    sclk_o  = 1'b0;
    mosi_o  = 1'b0;
  end

  // ----------------------------------------------------------------
  // one frame of n bits, msb first, each clock level two cycles or more
  // ----------------------------------------------------------------
  task automatic xfer(input logic [31:0] f, input int n,
                      output logic [31:0] a);
    a = '0;
    @(posedge clk_sys_i) csb_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i) mosi_o <= f[31-i];
      @(posedge clk_sys_i);
      @(posedge clk_sys_i) begin
        sclk_o    <= 1'b1;
        a[31-i]    = miso_i;  // answer bit settled since last fall
      end
      @(posedge clk_sys_i);
      @(posedge clk_sys_i) sclk_o <= 1'b0;
    end
    @(posedge clk_sys_i);
    // released data line must not keep showing the last bit
    @(posedge clk_sys_i) begin
      csb_n_o <= 1'b1;
      mosi_o  <= ~mosi_o;
    end
    repeat (4) @(posedge clk_sys_i);
  endtask : xfer
endmodule : mrc_host_model

`default_nettype wire

// ===== sim/mrc_regs_tb_top.sv
/*
  Self-checking bench for the mode and regulator control bank.
  Assumes the host model above and the answer-on-next-frame protocol.
*/
`default_nettype none

module mrc_regs_tb_top
  import mrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk_sys_i = 1'b0;
  logic              srst_i = 1'b1;
  logic              csb_n, sclk, mosi, miso;
  logic              pll = 1'b0, ext = 1'b0, norm = 1'b1, pda = 1'b1;
  logic              ext_dis, stby, wake_input_1, wake_input_2, pd_en;
  logic [NRAIL-1:0]  dis, en;
  logic [15:0]       seen = '0;
  int                hi = 0;
  int                mismatches = 0;
  int                comparisons = 0;
  mrc_word_t         d;
  logic [31:0]       ans;

  // ----------------------------------------------------------------
  // clock, design, host
  // ----------------------------------------------------------------
  always #50 clk_sys_i = ~clk_sys_i;

  mrc_regs dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .csb_n_i(csb_n),
    .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso), .pll_lock_i(pll),
    .ext_clk_selected_i(ext), .main_normal_i(norm),
    .pulldown_auto_i(pda), .external_clock_select_disable_o(ext_dis),
    .standby_request_o(stby), .wake_input_1_disable_o(wake_input_1),
    .wake_input_2_disable_o(wake_input_2), .preregulator_pulldown_en_o(pd_en),
    .rail_disable_req_o(dis), .rail_enable_req_o(en));

  mrc_host_model host (.clk_sys_i(clk_sys_i), .csb_n_o(csb_n),
    .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso));

  // collects request pulses and the cycles they stand high
  always @(posedge clk_sys_i) begin
    seen = seen | {ext_dis, stby, dis, en};
    if (|{ext_dis, stby, dis, en}) hi++;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] frm(logic w, logic [5:0] a, mrc_word_t v);
    return {w, a, 1'b0, v[23:8], 8'h00};
  endfunction : frm

  task automatic chk(string what, logic [23:0] sv, logic [23:0] ev);
    comparisons++;
    if (sv !== ev) begin
      mismatches++;
      $display("BAD %s expected %06h seen %06h", what, ev, sv);
    end
  endtask : chk

  task automatic wr(logic [5:0] a, mrc_word_t v);
    logic [31:0] r;
    @(negedge clk_sys_i);
    seen = '0;
    hi   = 0;
    host.xfer(frm(1'b1, a, v), 32, r);
  endtask : wr

  // the answer of a frame arrives during the following one
  task automatic rd(logic [5:0] a, output mrc_word_t v);
    logic [31:0] r;
    host.xfer(frm(1'b0, a, '0), 32, r);
    host.xfer(frm(1'b0, ADDR_COMM, '0), 32, r);
    v = {r[23:8], 8'h00};
  endtask : rd

  task automatic finish_test();
    $display("counts: comparisons %0d mismatches %0d", comparisons,
             mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // hang guard
  // ----------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    mismatches++;
    $display("BAD run length expected end seen hang");
    finish_test();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(ADDR_MODE, d);
    chk("mode reset", d, 24'h002000);
    rd(ADDR_REGC, d);
    chk("regc reset", d, 24'h000000);
    chk("pulldown auto", pd_en, 24'h1);
    $display("test reset done");
    pll  <= 1'b1;
    ext  <= 1'b1;
    norm <= 1'b0;
    rd(ADDR_MODE, d);
    chk("mode status", d, 24'h018000);
    $display("test status done");
    wr(ADDR_MODE, 24'h004700);
    chk("mode pulses", seen, 24'hC000);
    chk("mode pulse width", 24'(hi), 24'h1);
    chk("wake disables", {wake_input_2, wake_input_1}, 24'h3);
    rd(ADDR_MODE, d);
    chk("mode readback", d, 24'h018600);
    wr(ADDR_MODE, 24'h000200);
    chk("mode zeros", seen, 24'h0);
    chk("wake one only", {wake_input_2, wake_input_1}, 24'h1);
    $display("test mode done");
    for (int i = 0; i < NRAIL; i++) begin
      wr(ADDR_REGC, 24'h1 << (DIS_LSB + i));
      chk("disable req", seen, 24'h1 << (7 + i));
      chk("disable width", 24'(hi), 24'h1);
      wr(ADDR_REGC, 24'h1 << (EN_LSB + i));
      chk("enable req", seen, 24'h1 << i);
      chk("enable width", 24'(hi), 24'h1);
    end
    $display("test rails done");
    wr(ADDR_REGC, 24'h800000);
    chk("override on", pd_en, 24'h0);
    rd(ADDR_REGC, d);
    chk("regc readback", d, 24'h800000);
    wr(ADDR_REGC, 24'h000000);
    chk("override off", pd_en, 24'h1);
    pda <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk("auto follows", pd_en, 24'h0);
    $display("test pulldown done");
    rd(ADDR_COMM, d);
    chk("no error", d, 24'h000000);
    wr(ADDR_MODE, 24'h010400);
    chk("bad write dropped", wake_input_2, 24'h0);
    host.xfer(frm(1'b1, ADDR_MODE, 24'h000400), 31, ans);
    chk("short frame dropped", wake_input_2, 24'h0);
    rd(6'h3F, d);
    chk("unmapped read", d, 24'h000000);
    rd(ADDR_COMM, d);
    chk("errors set", d, 24'h001800);
    wr(ADDR_COMM, 24'h001800);
    rd(ADDR_COMM, d);
    chk("errors cleared", d, 24'h000000);
    $display("test errors done");
    norm <= 1'b1;
    @(posedge clk_sys_i) srst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("wake after reset", {wake_input_2, wake_input_1}, 24'h0);
    rd(ADDR_MODE, d);
    chk("mode after reset", d, 24'h01A000);
    $display("test second reset done");
    finish_test();
  end
endmodule : mrc_regs_tb_top

`default_nettype wire
